// file: hw/acotr_regs.sv
/*
  Offset trim register bank for the converter cores: five 12-bit trims,
  fuse defaults, calibration-state access gating, per-core trim selection.
  Assumes the fuse store output is stable while fuse_load is high, and that
  calibration state comes from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module acotr_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic fuse_load,
  input wire logic [59:0] fuse_trim,
  input wire acotr_pkg::acotr_cal_t cal_state,
  input wire acotr_pkg::acotr_input_t core2_input,
  input wire acotr_pkg::acotr_input_t core3_input,
  output acotr_pkg::acotr_trim_out_t trim_out,
  output logic core3_trim_valid,
  output logic access_allowed,
  output logic access_refused
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ************************************************************
  // Decode and access gate
  // ************************************************************
  function automatic logic [3:0] acotr_decode(input logic [11:0] a);
    logic [3:0] r;
    r = 4'hf;
    unique case (a)
      acotr_pkg::CORE0_OFFSET_TRIM_ADDR: r = {1'b0, acotr_pkg::IDX_CORE0};
      acotr_pkg::CORE1_OFFSET_TRIM_ADDR: r = {1'b0, acotr_pkg::IDX_CORE1};
      acotr_pkg::CORE2_INPUT_A_OFFSET_TRIM_ADDR: r = {1'b0, acotr_pkg::IDX_CORE2_A};
      acotr_pkg::CORE2_INPUT_B_OFFSET_TRIM_ADDR: r = {1'b0, acotr_pkg::IDX_CORE2_B};
      acotr_pkg::CORE3_INPUT_C_OFFSET_TRIM_ADDR: r = {1'b0, acotr_pkg::IDX_CORE3_C};
      default: r = 4'hf;
    endcase
    return r;
  endfunction

  wire logic [3:0] sel = acotr_decode(reg_addr);
  wire logic hit_trim = !sel[3];
  wire logic hit_status = (reg_addr == acotr_pkg::TRIM_ACCESS_STATUS_ADDR);

  wire logic gate_busy = cal_state.offset_calibration_busy;
  wire logic gate_bg = cal_state.background_calibration_enable
                     && cal_state.background_offset_tracking_enable;
  wire logic gate_fg = cal_state.offset_calibration_enable && !gate_bg
                     && !cal_state.foreground_calibration_done;
  wire logic allowed = !(gate_busy || gate_bg || gate_fg);

  // Refused accesses are dropped so a running calibration is never corrupted
  wire logic do_write = reg_write && hit_trim && allowed;
  wire logic refuse = (reg_write || reg_read) && hit_trim && !allowed;

  // ************************************************************
  // Trim store
  // ************************************************************
  logic [acotr_pkg::TRIM_W-1:0] trim [acotr_pkg::NUM_TRIM];
  logic refused_flag;
  logic [15:0] rdata;

  // Reserved bits are not stored, so they read back zero
  wire logic [11:0] wr_trim = reg_wdata[acotr_pkg::TRIM_MSB:acotr_pkg::TRIM_LSB];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < acotr_pkg::NUM_TRIM; i++) begin
        trim[i] <= acotr_pkg::TRIM_RESET[11:0];
      end
    end else if (fuse_load) begin
      for (int i = 0; i < acotr_pkg::NUM_TRIM; i++) begin
        trim[i] <= fuse_trim[i*12 +: 12];
      end
    end else if (do_write) begin
      trim[sel[2:0]] <= wr_trim;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refused_flag <= 1'b0;
    end else if (refuse) begin
      refused_flag <= 1'b1;
    end else if (reg_write && hit_status && reg_wdata[1]) begin
      refused_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  wire logic [15:0] trim_word = {4'h0, trim[sel[2:0]]};
  wire logic [15:0] status_word = {14'h0, refused_flag, allowed};
  wire logic [15:0] next_rdata = !reg_read ? 16'h0000 :
                                 (hit_trim && allowed) ? trim_word :
                                 hit_status ? status_word :
                                 acotr_pkg::UNMAPPED_READ;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;
  assign access_allowed = allowed;
  assign access_refused = refused_flag;

  // ************************************************************
  // Trim application to the cores
  // ************************************************************
  // Unsigned trim outputs
  acotr_pkg::acotr_trim_out_t next_trim_out;
  acotr_pkg::acotr_trim_out_t trim_q;
  logic core3_valid_q;

  wire logic [11:0] core2_sel = (core2_input == acotr_pkg::ACOTR_IN_SECOND)
                              ? trim[acotr_pkg::IDX_CORE2_B] : trim[acotr_pkg::IDX_CORE2_A];
  // Core 3 third input pair only
  wire logic core3_c = (core3_input == acotr_pkg::ACOTR_IN_THIRD);
  // Core 2 drives only its selected input trim; core 3 outputs zero off its third input
  assign next_trim_out = '{core0: trim[acotr_pkg::IDX_CORE0],
                           core1: trim[acotr_pkg::IDX_CORE1],
                           core2: core2_sel,
                           core3: core3_c ? trim[acotr_pkg::IDX_CORE3_C] : 12'h000};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= '0;
      core3_valid_q <= 1'b0;
    end else begin
      trim_q <= next_trim_out;
      core3_valid_q <= core3_c;
    end
  end

  assign trim_out = trim_q;
  assign core3_trim_valid = core3_valid_q;

endmodule
`default_nettype wire

// file: hw/acotr_pkg.sv
/*
  Holds the register map, field layout, reset values and the carrier
  types of the converter-core offset trim register bank.
  Assumes a plain register port with 16-bit data and 12-bit addresses.
*/
package acotr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int TRIM_W = 12;
  localparam int NUM_TRIM = 5;

  localparam logic [11:0] CORE0_OFFSET_TRIM_ADDR = 12'h330;
  localparam logic [11:0] CORE1_OFFSET_TRIM_ADDR = 12'h332;
  localparam logic [11:0] CORE2_INPUT_A_OFFSET_TRIM_ADDR = 12'h334;
  localparam logic [11:0] CORE2_INPUT_B_OFFSET_TRIM_ADDR = 12'h336;
  localparam logic [11:0] CORE3_INPUT_C_OFFSET_TRIM_ADDR = 12'h338;
  // Own status register: bit 0 access allowed, bit 1 sticky access refused, cleared by writing 1 to it
  localparam logic [11:0] TRIM_ACCESS_STATUS_ADDR = 12'h33e;

  localparam int TRIM_LSB = 0;
  localparam int TRIM_MSB = 11;
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // Index of each trim inside the store
  localparam logic [2:0] IDX_CORE0 = 3'h0;
  localparam logic [2:0] IDX_CORE1 = 3'h1;
  localparam logic [2:0] IDX_CORE2_A = 3'h2;
  localparam logic [2:0] IDX_CORE2_B = 3'h3;
  localparam logic [2:0] IDX_CORE3_C = 3'h4;

  typedef struct packed {
    logic offset_calibration_enable;
    logic background_calibration_enable;
    logic background_offset_tracking_enable;
    logic foreground_calibration_done;
    logic offset_calibration_busy;
  } acotr_cal_t;

  typedef struct packed {
    logic [TRIM_W-1:0] core0;
    logic [TRIM_W-1:0] core1;
    logic [TRIM_W-1:0] core2;
    logic [TRIM_W-1:0] core3;
  } acotr_trim_out_t;

  typedef enum logic [1:0] {
    ACOTR_IN_FIRST = 2'b00,
    ACOTR_IN_SECOND = 2'b01,
    ACOTR_IN_THIRD = 2'b11,
    ACOTR_IN_FOURTH = 2'b10
  } acotr_input_t;

endpackage

// file: verification/acotr_sva.sv
/* Port checker for the offset trim bank.
   Bound to every acotr_regs instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module acotr_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic fuse_load,
  input wire logic [59:0] fuse_trim,
  input wire acotr_pkg::acotr_cal_t cal_state,
  input wire acotr_pkg::acotr_input_t core3_input,
  input wire acotr_pkg::acotr_trim_out_t trim_out,
  input wire logic core3_trim_valid,
  input wire logic access_allowed,
  input wire logic access_refused
);
  // ********
  // Properties
  // ********
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire hit = reg_addr[11:4] == 8'h33 && reg_addr[3:0] <= 4'h8 && !reg_addr[0];
  wire os = cal_state.offset_calibration_enable;
  wire busy = cal_state.offset_calibration_busy;
  wire fg = cal_state.foreground_calibration_done;
  wire bgt = cal_state.background_calibration_enable
             && cal_state.background_offset_tracking_enable;
  sequence s_wr0;
    reg_write && access_allowed && !fuse_load && reg_addr == 12'h330;
  endsequence
  property p_wr0;
    s_wr0 |=> ##1 trim_out.core0 == $past(reg_wdata[11:0], 2);
  endproperty
  a_wr0: assert property (p_wr0) else $error("core0 trim wrong");
  property p_fuse;
    fuse_load |=> ##1 trim_out.core1 == $past(fuse_trim[23:12], 2);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse default wrong");
  property p_rdz;
    !$past(reg_read) |-> reg_rdata == 16'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  property p_refuse;
    (reg_write || reg_read) && hit && !access_allowed |=> access_refused && reg_rdata == 16'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("gated access not refused");
  property p_busy;
    busy |-> !access_allowed;
  endproperty
  a_busy: assert property (p_busy) else $error("access open while busy");
  property p_bgt;
    bgt |-> !access_allowed;
  endproperty
  a_bgt: assert property (p_bgt) else $error("access open while tracking");
  property p_fgw;
    os && !fg |-> !access_allowed;
  endproperty
  a_fgw: assert property (p_fgw) else $error("access before foreground done");
  property p_free;
    !busy && !bgt && !(os && !fg) |-> access_allowed;
  endproperty
  a_free: assert property (p_free) else $error("access wrongly closed");
  property p_c3;
    core3_input != acotr_pkg::ACOTR_IN_THIRD |=> !core3_trim_valid && trim_out.core3 == 12'h0;
  endproperty
  a_c3: assert property (p_c3) else $error("core3 trim off input");
endmodule
bind acotr_regs acotr_sva chk_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .fuse_load(fuse_load), .fuse_trim(fuse_trim), .cal_state(cal_state),
  .core3_input(core3_input), .trim_out(trim_out), .core3_trim_valid(core3_trim_valid),
  .access_allowed(access_allowed), .access_refused(access_refused));
`default_nettype wire

// file: verification/tb.sv
/* Bench for the offset trim bank: bus tasks, gating table, trim selection.
   Assumes acotr_pkg and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********
  // Drivers and tasks
  // ********
  logic mclk = 1'h0, reset_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0, fuse_load = 1'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic [59:0] fuse_trim = 60'h5a54b43c32d21e1;
  acotr_pkg::acotr_cal_t cal_state = '0;
  acotr_pkg::acotr_input_t core2_input = acotr_pkg::ACOTR_IN_FIRST;
  acotr_pkg::acotr_input_t core3_input = acotr_pkg::ACOTR_IN_FIRST;
  acotr_pkg::acotr_trim_out_t trim_out;
  logic core3_trim_valid, access_allowed, access_refused;
  int mismatches = 0, check_count = 0;
  logic [11:0] adr [5] = '{12'h330, 12'h332, 12'h334, 12'h336, 12'h338};
  logic [4:0] cv [7] = '{5'h00, 5'h01, 5'h10, 5'h12, 5'h0c, 5'h1a, 5'h08};
  logic [6:0] ce = 7'h69;
  acotr_regs dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .fuse_load(fuse_load), .fuse_trim(fuse_trim), .cal_state(cal_state),
    .core2_input(core2_input), .core3_input(core3_input), .trim_out(trim_out),
    .core3_trim_valid(core3_trim_valid), .access_allowed(access_allowed),
    .access_refused(access_refused));
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'h0;
  endtask
  // Data stands one cycle only, so it is sampled just after the answering edge
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'h0;
    #1 chk(reg_rdata, e, "rdata");
  endtask
  task automatic cal(input logic [4:0] v, input logic e);
    @(posedge mclk);
    cal_state <= v;
    #1 chk(access_allowed, e, "allowed");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 5; i++) rd(adr[i], 16'h0);
    @(posedge mclk);
    fuse_load <= 1'h1;
    @(posedge mclk);
    fuse_load <= 1'h0;
    for (int i = 0; i < 5; i++) rd(adr[i], {4'h0, fuse_trim[i*12 +: 12]});
    $display("reset and fuse test done");
    for (int i = 0; i < 5; i++) wr(adr[i], 16'h0ff0 + 16'(i));
    for (int i = 0; i < 5; i++) rd(adr[i], 16'h0ff0 + 16'(i));
    chk(trim_out, 48'hff0ff1ff2000, "trim");
    chk(core3_trim_valid, 48'h0, "core3 valid");
    @(posedge mclk);
    core2_input <= acotr_pkg::ACOTR_IN_SECOND;
    core3_input <= acotr_pkg::ACOTR_IN_THIRD;
    repeat (2) @(posedge mclk);
    #1 chk(trim_out, 48'hff0ff1ff3ff4, "trim");
    chk(core3_trim_valid, 48'h1, "core3 valid");
    $display("trim test done");
    for (int i = 0; i < 7; i++) cal(cv[i], ce[i]);
    cal(5'h18, 1'h0);
    cal(5'h1e, 1'h0);
    cal(5'h01, 1'h0);
    wr(12'h330, 16'h0123);
    rd(12'h330, 16'h0);
    chk(access_refused, 48'h1, "refused");
    cal(5'h00, 1'h1);
    rd(12'h330, 16'h0ff0);
    rd(12'h33e, 16'h0003);
    wr(12'h33e, 16'h0002);
    rd(12'h33e, 16'h0001);
    rd(12'h33c, 16'h0);
    $display("gating test done");
    end_of_test;
  end
endmodule
`default_nettype wire
